/* File: hw/tocp_timer.sv */
`timescale 1ns/1ps

module tocp_timer #(
  parameter int NCH = 6 // Channel count, even.
) (
  input  wire logic             i_clk,     // Bus clock, 25 MHz.
  input  wire logic             i_rst_n,   // Async reset, active low.
  input  wire logic             i_psel,    // APB select.
  input  wire logic             i_penable, // APB enable.
  input  wire logic             i_pwrite,  // APB direction.
  input  wire logic [7:0]       i_paddr,   // APB byte address.
  input  wire logic [31:0]      i_pwdata,  // APB write data.
  output logic      [31:0]      o_prdata,  // APB read data.
  output logic                  o_pready,  // APB ready.
  output logic                  o_pslverr, // APB error.
  output logic      [NCH-1:0]   o_pin,     // Channel pin levels.
  output logic      [NCH-1:0]   o_pin_oe_n,// Pin drive enable, low drives.
  output logic      [NCH-1:0]   o_ch_irq,  // Per-channel requests.
  output logic                  o_ovf_irq, // Overflow request.
  output logic      [15:0]      o_count,   // Counter value.
  output logic                  o_ovf      // Overflow event pulse.
);

  initial begin
    if (NCH < 2 || NCH > 8 || NCH % 2 != 0) begin
      $error("NCH must be even and within 2..8.");
    end
  end

  // ---------------------------------------------------------------------------
  // State record.
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]           ctrl;
    logic [15:0]          modv;
    logic [15:0]          cnt;
    logic [NCH-1:0][7:0]  sc;
    logic [NCH-1:0][15:0] val;
    logic [NCH-1:0]       pin;
    logic [NCH/2-1:0]     odd_act;  // Pair: odd value is active.
    logic [NCH/2-1:0]     odd_pend; // Pair: select at next overflow.
    logic [NCH/2-1:0]     sel_pend; // Pair: a selection is pending.
    logic                 ovf;
    logic [31:0]          rdata;
  } tocp_st_t;

  tocp_st_t st;
  tocp_st_t next_st;
  logic     tick;

  // Address decode shared by read and write paths.
  function automatic int tocp_idx(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] d;
    d = a - b;
    if (a >= b && d[1:0] == 2'b00 && int'(d[7:2]) < NCH) begin
      return int'(d[7:2]);
    end
    return -1;
  endfunction : tocp_idx

  // Effective pair link: buffered bit of an even channel.
  function automatic logic tocp_link(input tocp_st_t s, input int ch);
    return s.sc[ch - ch % 2][tocp_pkg::TOCP_SC_MSB];
  endfunction : tocp_link

  wire wr = i_psel && i_penable && i_pwrite;
  wire rd = i_psel && !i_penable && !i_pwrite;

  // A counter reset write cancels the tick of its own cycle, so checks use
  // this qualified step. A compare acts on the count that the tick lands
  // on, which makes the pulse exactly the channel value long.
  logic        step;
  logic [15:0] cnt_up;
  assign step   = tick && !(wr && i_paddr == tocp_pkg::TOCP_OFS_CTRL &&
                            i_pwdata[tocp_pkg::TOCP_CTRL_RST]);
  assign cnt_up = (st.cnt == st.modv) ? 16'h0000 : st.cnt + 16'h0001;

  // ---------------------------------------------------------------------------
  // Prescaler.
  // ---------------------------------------------------------------------------
  tocp_prescale u_ps (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_clr   (wr && i_paddr == tocp_pkg::TOCP_OFS_CTRL &&
              i_pwdata[tocp_pkg::TOCP_CTRL_RST]),
    .i_run   (!st.ctrl[tocp_pkg::TOCP_CTRL_STOP]),
    .i_sel   (st.ctrl[tocp_pkg::TOCP_CTRL_PS_LSB +: 3]),
    .o_tick  (tick)
  );

  // ---------------------------------------------------------------------------
  // Counter, compare, pair selection and register writes.
  // ---------------------------------------------------------------------------
  // Hardware flag sets are applied after the software clears so a set in
  // the clearing cycle survives.
  always_comb begin
    logic        at_mod;
    logic        cnt_tick;
    logic [15:0] cmpv;
    logic        match;
    int          wi;
    int          vi;
    int          e;
    next_st     = st;
    next_st.ovf = 1'b0;
    at_mod      = (st.cnt == st.modv);
    cnt_tick    = tick;
    wi          = tocp_idx(i_paddr, tocp_pkg::TOCP_OFS_CHSC0);
    vi          = tocp_idx(i_paddr, tocp_pkg::TOCP_OFS_CHVAL0);
    e           = 0;
    cmpv        = 16'h0000;
    match       = 1'b0;

    // Software writes; writes to channel values land immediately.
    if (wr) begin
      if (i_paddr == tocp_pkg::TOCP_OFS_CTRL) begin
        next_st.ctrl[6:0] = i_pwdata[6:0];
        next_st.ctrl[tocp_pkg::TOCP_CTRL_RST] = 1'b0;
        if (!i_pwdata[tocp_pkg::TOCP_CTRL_TOF]) begin
          next_st.ctrl[tocp_pkg::TOCP_CTRL_TOF] = 1'b0;
        end
        if (i_pwdata[tocp_pkg::TOCP_CTRL_RST]) begin
          next_st.cnt = 16'h0000;
          cnt_tick    = 1'b0;
        end
      end else if (i_paddr == tocp_pkg::TOCP_OFS_MOD) begin
        next_st.modv = i_pwdata[15:0];
      end
      if (wi >= 0) begin
        next_st.sc[wi][6:0] = i_pwdata[6:0];
        if (!i_pwdata[tocp_pkg::TOCP_SC_FLAG]) begin
          next_st.sc[wi][tocp_pkg::TOCP_SC_FLAG] = 1'b0;
        end
      end
      if (vi >= 0) begin
        next_st.val[vi] = i_pwdata[15:0];
        // Remember the last written half of a linked pair.
        if (tocp_link(st, vi)) begin
          next_st.odd_pend[vi/2] = (vi % 2 == 1);
          next_st.sel_pend[vi/2] = 1'b1;
        end
      end
    end

    if (cnt_tick) begin
      // Counter wraps after reaching the modulo: period is modv+1.
      next_st.cnt = at_mod ? 16'h0000 : st.cnt + 16'h0001;
      if (at_mod) begin
        next_st.ovf = 1'b1;
        next_st.ctrl[tocp_pkg::TOCP_CTRL_TOF] = 1'b1;
      end
      for (int c = 0; c < NCH; c++) begin
        e = c - c % 2;
        // The odd channel of a linked pair is idle.
        if (!(c % 2 == 1 && tocp_link(st, c))) begin
          if (tocp_link(st, c)) begin
            cmpv = st.odd_act[c/2] ? st.val[c+1] : st.val[c];
          end else begin
            cmpv = st.val[c];
          end
          // Only a full 16-bit equality counts; a value already passed
          // waits for the next period.
          match = (cnt_up == cmpv);
          if (match) begin
            next_st.sc[c][tocp_pkg::TOCP_SC_FLAG] = 1'b1;
          end
          if (at_mod && st.sc[c][tocp_pkg::TOCP_SC_TOV]) begin
            // Overflow toggles; max duty holds the pin high.
            next_st.pin[c] = st.sc[c][tocp_pkg::TOCP_SC_MAX] ? 1'b1
                                                              : !st.pin[c];
          end else if (match && !st.sc[c][tocp_pkg::TOCP_SC_MAX]) begin
            // Level action; with no overflow toggle, clear and set settle.
            unique case ({st.sc[c][tocp_pkg::TOCP_SC_ELB],
                          st.sc[c][tocp_pkg::TOCP_SC_ELA]})
              2'b01: next_st.pin[c] = !st.pin[c];
              2'b10: next_st.pin[c] = 1'b0;
              2'b11: next_st.pin[c] = 1'b1;
              2'b00: next_st.pin[c] = st.pin[c];
            endcase
          end
        end
      end
      // At overflow, switch each pair with a pending selection to its pending half.
      if (at_mod) begin
        for (int p = 0; p < NCH/2; p++) begin
          if (st.sel_pend[p]) begin
            next_st.odd_act[p]  = st.odd_pend[p];
            next_st.sel_pend[p] = 1'b0;
          end
        end
      end
    end

    // Unlinking resets the pair to start from the even value.
    for (int p = 0; p < NCH/2; p++) begin
      if (!next_st.sc[2*p][tocp_pkg::TOCP_SC_MSB]) begin
        next_st.odd_act[p]  = 1'b0;
        next_st.sel_pend[p] = 1'b0;
      end
    end

    // Read data captured in setup, presented during access.
    if (rd) begin
      next_st.rdata = 32'h0000_0000;
      if (i_paddr == tocp_pkg::TOCP_OFS_CTRL) begin
        next_st.rdata[7:0] = st.ctrl;
      end else if (i_paddr == tocp_pkg::TOCP_OFS_MOD) begin
        next_st.rdata[15:0] = st.modv;
      end else if (i_paddr == tocp_pkg::TOCP_OFS_CNT) begin
        next_st.rdata[15:0] = st.cnt;
      end else if (wi >= 0) begin
        next_st.rdata[7:0] = st.sc[wi];
      end else if (vi >= 0) begin
        next_st.rdata[15:0] = st.val[vi];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st      <= '0;
      st.ctrl <= tocp_pkg::TOCP_CTRL_RESET;
      st.modv <= tocp_pkg::TOCP_MOD_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs.
  // ---------------------------------------------------------------------------
  // Unmapped addresses answer zero without error; registers read on setup.
  assign o_prdata  = st.rdata;
  assign o_pready  = 1'b1;
  assign o_pslverr = 1'b0;
  assign o_count   = st.cnt;
  assign o_ovf     = st.ovf;
  assign o_ovf_irq = st.ctrl[tocp_pkg::TOCP_CTRL_TOF] &&
                     st.ctrl[tocp_pkg::TOCP_CTRL_TOIE];

  // Pin drive: a channel drives when set up for output action, except the
  // odd channel of a linked pair, whose pin is left to general use.
  for (genvar g = 0; g < NCH; g++) begin : g_out
    wire busy = st.sc[g][tocp_pkg::TOCP_SC_MSA] ||
                st.sc[g][tocp_pkg::TOCP_SC_MSB] ||
                st.sc[g][tocp_pkg::TOCP_SC_ELA] ||
                st.sc[g][tocp_pkg::TOCP_SC_ELB];
    wire idle = (g % 2 == 1) && tocp_link(st, g);
    assign o_pin[g]      = st.pin[g];
    assign o_pin_oe_n[g] = !(busy && !idle);
    assign o_ch_irq[g]   = st.sc[g][tocp_pkg::TOCP_SC_FLAG] &&
                           st.sc[g][tocp_pkg::TOCP_SC_IE];
  end

  // ---------------------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_ovf_wrap: assert property (o_ovf |-> o_count == 16'h0000)
    else $error("Counter did not wrap at overflow.");
  a_flag_irq: assert property (o_ch_irq[0] |-> st.sc[0][7] && st.sc[0][6])
    else $error("Channel request without flag and enable.");
  a_clear_act: assert property (step && cnt_up == st.val[0] &&
      st.sc[0][3:2] == 2'b10 && st.sc[0][1:0] == 2'b00 && !st.sc[0][5]
      |=> !o_pin[0])
    else $error("Clear action failed.");
  a_set_act: assert property (step && cnt_up == st.val[0] &&
      st.sc[0][3:2] == 2'b11 && st.sc[0][1:0] == 2'b00 && !st.sc[0][5]
      |=> o_pin[0])
    else $error("Set action failed.");
  a_flag_set: assert property (step && cnt_up == st.val[0] && !st.sc[0][5]
      |=> st.sc[0][7])
    else $error("Compare flag not set.");
  a_max_duty: assert property (step && st.cnt == st.modv &&
      st.sc[0][1:0] == 2'b11 |=> o_pin[0])
    else $error("Full duty not held.");
  a_ovf_tgl: assert property (step && st.cnt == st.modv &&
      st.sc[0][1:0] == 2'b10 |=> o_pin[0] != $past(o_pin[0]))
    else $error("Overflow toggle missing.");
  a_odd_free: assert property (st.sc[0][5] |-> o_pin_oe_n[1])
    else $error("Odd pin driven while linked.");
  a_swap_ovf: assert property (st.odd_act[0] != $past(st.odd_act[0]) &&
      st.sc[0][5] |-> $past(o_ovf) || o_ovf || $past(tick))
    else $error("Pair swapped outside overflow.");

  c_ovf:  cover property (o_ovf);
  c_link: cover property (st.sc[0][5] && st.odd_act[0]);
  c_irq:  cover property (o_ch_irq[0]);

endmodule : tocp_timer

/* File: hw/tocp_pkg.sv */
package tocp_pkg;

  // ---------------------------------------------------------------------------
  // Register map: one aligned 32-bit word per register, byte addresses.
  // ---------------------------------------------------------------------------
  localparam logic [7:0] TOCP_OFS_CTRL   = 8'h00;
  localparam logic [7:0] TOCP_OFS_MOD    = 8'h04;
  localparam logic [7:0] TOCP_OFS_CNT    = 8'h08;
  localparam logic [7:0] TOCP_OFS_CHSC0  = 8'h10;
  localparam logic [7:0] TOCP_OFS_CHVAL0 = 8'h30;
  localparam logic [7:0] TOCP_CH_STRIDE  = 8'h04;

  // ---------------------------------------------------------------------------
  // Timer control word fields.
  // ---------------------------------------------------------------------------
  localparam int TOCP_CTRL_PS_LSB = 0;
  localparam int TOCP_CTRL_RST    = 4;
  localparam int TOCP_CTRL_STOP   = 5;
  localparam int TOCP_CTRL_TOIE   = 6;
  localparam int TOCP_CTRL_TOF    = 7;
  localparam logic [7:0] TOCP_CTRL_RESET = 8'h20;

  // ---------------------------------------------------------------------------
  // Channel control/status fields.
  // ---------------------------------------------------------------------------
  localparam int TOCP_SC_MAX  = 0;
  localparam int TOCP_SC_TOV  = 1;
  localparam int TOCP_SC_ELA  = 2;
  localparam int TOCP_SC_ELB  = 3;
  localparam int TOCP_SC_MSA  = 4;
  localparam int TOCP_SC_MSB  = 5;
  localparam int TOCP_SC_IE   = 6;
  localparam int TOCP_SC_FLAG = 7;
  localparam logic [7:0] TOCP_SC_RESET = 8'h00;
  localparam logic [15:0] TOCP_MOD_RESET = 16'hFFFF;

endpackage : tocp_pkg

/* File: hw/tocp_prescale.sv */
`timescale 1ns/1ps

// Prescaler: one-cycle tick every 2**sel bus clocks, select 0..7.
module tocp_prescale (
  input  wire logic       i_clk,   // Bus clock.
  input  wire logic       i_rst_n, // Asynchronous reset, active low.
  input  wire logic       i_clr,   // Restart the divider.
  input  wire logic       i_run,   // Counting allowed.
  input  wire logic [2:0] i_sel,   // Rate select.
  output logic            o_tick   // One-cycle enable pulse.
);

  typedef struct packed {
    logic [6:0] div;
  } tocp_ps_t;

  tocp_ps_t st;
  tocp_ps_t next_st;

  // A tick fires when the low sel bits of the divider are all ones.
  always_comb begin
    logic [6:0] mask;
    mask    = 7'((8'h01 << i_sel) - 8'h01);
    next_st = st;
    o_tick  = i_run && ((st.div & mask) == mask);
    if (i_clr) begin
      next_st.div = 7'h00;
    end else if (i_run) begin
      next_st.div = st.div + 7'h01;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : tocp_prescale

/* File: bench/tocp_load_model.sv */
`timescale 1ns/1ps

// Load on one channel pin: resolves the pad and times its pulses.
module tocp_load_model (
  input  wire logic        i_clk,    // Bus clock.
  input  wire logic        i_rst_n,  // Async reset, active low.
  input  wire logic        i_pin,    // Level the timer drives.
  input  wire logic        i_oe_n,   // Low while the timer drives.
  output logic             o_pad,    // Level seen by the load.
  output logic             o_meas,   // Pulse at each rising edge.
  output logic      [15:0] o_high,   // Last high time in clocks.
  output logic      [15:0] o_period  // Last rise-to-rise time.
);
  logic        last_drv;
  logic        prev;
  logic [15:0] run;

  // An undriven pad shows the inverse of the last driven level, so a
  // released pin can never pass for a held one.
  assign o_pad = !i_oe_n ? i_pin : ~last_drv;

  // Pulse timing; the high part is the pulse width reading.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {last_drv, prev, run, o_meas, o_high, o_period} <= '0;
    end else begin
      if (!i_oe_n) last_drv <= i_pin;
      prev   <= o_pad;
      o_meas <= 1'b0;
      run    <= run + 16'h0001;
      if (o_pad && !prev) begin
        o_period <= run;
        o_meas   <= 1'b1;
        run      <= 16'h0001;
      end
      if (!o_pad && prev) o_high <= run;
    end
  end
endmodule : tocp_load_model

/* File: bench/timer_output_compare_pwm_tb_top.sv */
`timescale 1ns/1ps

module timer_output_compare_pwm_tb_top;
  logic i_clk, i_rst_n, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, ovf_irq, ovf, pad, meas;
  logic [5:0] pin, oe_n, ch_irq;
  logic [15:0] count, high, period;
  logic [31:0] rd_q[$];
  logic [31:0] pw_q[$];
  int mismatches = 0;
  int samples_checked = 0;
  logic [7:0] sc_t[4] = '{8'h1A, 8'h1A, 8'h1E, 8'h14};
  logic [15:0] val_t[4] = '{16'h0080, 16'h0080, 16'h0040, 16'h0080};
  logic [2:0] ps_t[4] = '{3'h0, 3'h1, 3'h0, 3'h0};
  logic [15:0] hi_t[4] = '{16'h0080, 16'h0100, 16'h00C0, 16'h0100};
  logic [15:0] per_t[4] = '{16'h0100, 16'h0200, 16'h0100, 16'h0200};

  tocp_timer tocp_timer_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_pin(pin),
    .o_pin_oe_n(oe_n), .o_ch_irq(ch_irq), .o_ovf_irq(ovf_irq),
    .o_count(count), .o_ovf(ovf));

  tocp_load_model tocp_load_model_inst (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_pin(pin[0]), .i_oe_n(oe_n[0]), .o_pad(pad),
    .o_meas(meas), .o_high(high), .o_period(period));

  // ---------------------------------------------------------------
  // Clock, comparison and closing.
  // ---------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  // Watchers take the oldest note whenever a result shows up.
  always @(posedge i_clk) begin
    if (psel && penable && !pwrite && pready && rd_q.size() > 0)
      chk(prdata, rd_q.pop_front());
    if (meas && pw_q.size() > 0) chk({high, period}, pw_q.pop_front());
  end

  // ---------------------------------------------------------------
  // Bus and measurement tasks.
  // ---------------------------------------------------------------
  // The request stands until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) chk(1'b0, 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    rd_q.push_back(exp);
    apb(1'b0, a, 32'h0);
  endtask : rd

  // Stop and clear the counter, then program channel 0 and restart.
  task automatic cfg(input logic [7:0] sc, input logic [15:0] v,
                     input logic [2:0] ps);
    apb(1'b1, tocp_pkg::TOCP_OFS_CTRL, 32'h0000_0030);
    apb(1'b1, tocp_pkg::TOCP_OFS_MOD, 32'h0000_00FF);
    apb(1'b1, tocp_pkg::TOCP_OFS_CHVAL0, {16'h0, v});
    apb(1'b1, tocp_pkg::TOCP_OFS_CHSC0, {24'h0, sc});
    apb(1'b1, tocp_pkg::TOCP_OFS_CTRL, {29'h0, ps});
  endtask : cfg

  // Two periods to settle, then one timed pulse is expected.
  task automatic measure(input logic [15:0] hi, input logic [15:0] per);
    int n;
    n = 0;
    repeat (2 * per + 8) @(posedge i_clk);
    pw_q.push_back({hi, per});
    while (pw_q.size() > 0 && n < 4 * per) begin
      @(posedge i_clk);
      n++;
    end
    if (pw_q.size() > 0) begin
      pw_q.delete();
      chk(1'b0, 1'b1);
    end
    $display("test done hi %0d per %0d", hi, per);
  endtask : measure

  // ---------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------
  initial begin
    logic [15:0] r;
    i_rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    void'($urandom(32'hE0771567));
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    rd(tocp_pkg::TOCP_OFS_CTRL, 32'h20);
    rd(tocp_pkg::TOCP_OFS_MOD, 32'hFFFF);
    rd(tocp_pkg::TOCP_OFS_CHSC0, 32'h0);
    rd(8'hFC, 32'h0);
    chk(pslverr, 1'b0);
    // No overflow toggle: compares find the pin already low.
    cfg(8'h18, 16'h0080, 3'h0);
    repeat (600) @(posedge i_clk);
    chk(pad, 1'b0);
    // PWM cases; the last one toggles on compare at half the rate.
    for (int i = 0; i < 4; i++) begin
      cfg(sc_t[i], val_t[i], ps_t[i]);
      measure(hi_t[i], per_t[i]);
    end
    for (int i = 0; i < 2; i++) begin
      r = 16'($urandom_range(254, 1));
      cfg(8'h1A, r, 3'h0);
      measure(r, 16'h0100);
    end
    // Unbuffered updates synchronised as software should do them.
    cfg(8'h1A, 16'h0080, 3'h0);
    while (count != 16'h0090) @(posedge i_clk);
    apb(1'b1, tocp_pkg::TOCP_OFS_CHVAL0, 32'h40);
    measure(16'h0040, 16'h0100);
    while (count != 16'h0002) @(posedge i_clk);
    apb(1'b1, tocp_pkg::TOCP_OFS_CHVAL0, 32'hA0);
    measure(16'h00A0, 16'h0100);
    // Flags and requests.
    apb(1'b1, tocp_pkg::TOCP_OFS_CHSC0, 32'h5A);
    repeat (600) @(posedge i_clk);
    chk(ch_irq[0], 1'b1);
    rd(tocp_pkg::TOCP_OFS_CHSC0, 32'hDA);
    apb(1'b1, tocp_pkg::TOCP_OFS_CTRL, 32'h20);
    apb(1'b1, tocp_pkg::TOCP_OFS_CHSC0, 32'h5A);
    chk(ch_irq[0], 1'b0);
    apb(1'b1, tocp_pkg::TOCP_OFS_CHSC0, 32'h1A);
    apb(1'b1, tocp_pkg::TOCP_OFS_CTRL, 32'h40);
    repeat (600) @(posedge i_clk);
    chk(ch_irq[0], 1'b0);
    chk(ovf_irq, 1'b1);
    rd(tocp_pkg::TOCP_OFS_CTRL, 32'hC0);
    rd(tocp_pkg::TOCP_OFS_CHSC0, 32'h9A);
    // Full duty with max bit and overflow toggle.
    cfg(8'h1B, 16'h0080, 3'h0);
    repeat (600) @(posedge i_clk);
    chk(pad, 1'b1);
    // Linked pair; software writes only the inactive half.
    cfg(8'h2A, 16'h0040, 3'h0);
    measure(16'h0040, 16'h0100);
    chk(oe_n[1], 1'b1);
    apb(1'b1, tocp_pkg::TOCP_OFS_CHVAL0 + 8'h04, 32'hC0);
    measure(16'h00C0, 16'h0100);
    apb(1'b1, tocp_pkg::TOCP_OFS_CHVAL0, 32'h20);
    measure(16'h0020, 16'h0100);
    apb(1'b1, tocp_pkg::TOCP_OFS_CHSC0, 32'h3A);
    measure(16'h0020, 16'h0100);
    chk(oe_n[1], 1'b1);
    tally_and_finish();
  end

  // Whole run is about 13k clocks; this cuts a hang short.
  initial begin
    #(40 * 80000);
    mismatches++;
    tally_and_finish();
  end
endmodule : timer_output_compare_pwm_tb_top
